/* dv/ldm_ctrl_asserts.sv */
`timescale 1ns/10ps
module ldm_ctrl_asserts (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // host port
    input wire logic [7:0] io_addr_i,
    input wire logic       io_rd_i,
    input wire logic       io_rd_ready_o,
    input wire logic [7:0] io_rdata_o,
    input wire logic       io_rd_valid_o,
    // engine and channel state
    input wire logic [1:0] word_access_i,
    input wire logic [7:0] tc_i,
    input wire logic [1:0] byte_high_o,
    input wire logic [1:0] group_clear_o,
    input wire logic [7:0] chan_auto_o,
    input wire logic [7:0] chan_reload_o,
    input wire logic [7:0] chan_mask_o,
    input wire logic [7:0] chan_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // masks and reloads follow terminal count by one edge
    // only channels without autoinit must come back masked
    property p_tc_mask; (|(tc_i & ~chan_auto_o))
        |=> &(chan_mask_o | ~$past(tc_i & ~chan_auto_o)); endproperty
    a_tc_mask: assert property (p_tc_mask) else $error("tc left mask clear");
    property p_reload; !$past(rst_i) |-> chan_reload_o == $past(tc_i & chan_auto_o); endproperty
    a_reload: assert property (p_reload) else $error("bad reload pulse");
    // reads answer one edge later with the group mask
    property p_rd_lat; io_rd_i && io_rd_ready_o |=> io_rd_valid_o; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read valid late");
    property p_rd_mask; io_rd_i && io_rd_ready_o && io_addr_i == 8'h0F
        |=> io_rdata_o == {4'h0, $past(chan_mask_o[3:0])}; endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");
    // master clear leaves the high group masked, pointer low, no autoinit
    property p_mclr; group_clear_o[1] |-> chan_mask_o[7:4] == 4'hF && !byte_high_o[1]
        && chan_auto_o[7:4] == 4'h0; endproperty
    a_mclr: assert property (p_mclr) else $error("master clear incomplete");
    property p_req_mask; (chan_req_o & chan_mask_o) == 8'h00; endproperty
    a_req_mask: assert property (p_req_mask) else $error("masked request seen");
    property p_casc; chan_mask_o[4] |-> chan_req_o[3:0] == 4'h0; endproperty
    a_casc: assert property (p_casc) else $error("cascade mask ignored");
    // idle queue means nothing can clear the pointer on this edge
    property p_bptr; word_access_i[0] && io_rd_ready_o |=> byte_high_o[0] != $past(byte_high_o[0]);
    endproperty
    a_bptr: assert property (p_bptr) else $error("pointer did not toggle");
endmodule

bind ldm_ctrl ldm_ctrl_asserts chk_u (.clk_i, .rst_i, .io_addr_i, .io_rd_i, .io_rd_ready_o,
    .io_rdata_o, .io_rd_valid_o, .word_access_i, .tc_i, .byte_high_o, .group_clear_o,
    .chan_auto_o, .chan_reload_o, .chan_mask_o, .chan_req_o);

/* dv/ldm_ctrl_bench.sv */
`timescale 1ns/10ps
module ldm_ctrl_bench;
    import ldm_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0, cfg_hold_i = 1'b0;
    logic [7:0]  io_addr_i = 8'h00, io_wdata_i = 8'h00, tc_i = 8'h00, raise = 8'h00, dreq_i;
    logic [1:0]  word_access_i = 2'h0, byte_high_o, group_clear_o;
    logic        io_wr_ready_o, io_rd_ready_o, io_rd_valid_o;
    logic [7:0]  io_rdata_o, chan_decr_o, chan_auto_o, chan_reload_o, chan_mask_o, chan_req_o;
    logic [15:0] chan_xfer_o, chan_type_o, status_o;
    logic [5:0]  md [8] = '{default: 6'h00};
    logic [1:0]  xf [3] = '{2'h0, 2'h1, 2'h3};
    logic [7:0]  d, mk;
    int          n_mismatch = 0, tests_run = 0, i, c;

    ldm_ctrl dut_u (.clk_i, .rst_i, .io_addr_i, .io_wdata_i, .io_wr_i, .io_wr_ready_o, .io_rd_i,
        .io_rd_ready_o, .io_rdata_o, .io_rd_valid_o, .cfg_hold_i, .word_access_i, .tc_i,
        .byte_high_o, .group_clear_o, .chan_xfer_o, .chan_decr_o, .chan_auto_o, .chan_type_o,
        .chan_reload_o, .chan_mask_o, .chan_req_o, .status_o, .dreq_i);
    ldm_dreq_model dev_u (.clk_i, .raise_i(raise), .dreq_o(dreq_i));

    // 20 MHz clock
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // write and read hold the request until ready; settle drops it
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        io_addr_i = a;
        io_wdata_i = v;
        io_wr_i = 1'b1;
        // a stuck queue is caught by the watchdog
        while (io_wr_ready_o !== 1'b1)
            @(negedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic settle(input int n);
        io_wr_i = 1'b0;
        io_rd_i = 1'b0;
        repeat (n) @(negedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        io_addr_i = a;
        io_rd_i = 1'b1;
        while (io_rd_ready_o !== 1'b1)
            @(negedge clk_i);
        @(negedge clk_i);
        chk({io_rd_valid_o, 7'h0, io_rdata_o}, {8'h80, e});
        settle(1);
    endtask

    // cascade channels report no transfer type
    function automatic logic [1:0] exp_type(input logic [5:0] m);
        return (m[5:4] == 2'h3) ? 2'h0 : m[1:0];
    endfunction

    task automatic chk_modes();
        logic [5:0] g;
        for (int k = 0; k < 8; k++)
        begin
            g = {chan_xfer_o[2*k +: 2], chan_decr_o[k], chan_auto_o[k], chan_type_o[2*k +: 2]};
            chk({10'h0, g}, {10'h0, md[k][5:2], exp_type(md[k])});
        end
    endtask

    // watchdog, far beyond the expected run
    initial
    begin
        #(50 * 20000);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        void'($urandom(7720));
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        chk({chan_mask_o, 6'h0, byte_high_o}, 16'hFF00);
        chk_modes();
        rd(8'h0F, 8'h0F);
        rd(8'hDE, 8'h0F);
        $display("reset test done");
        for (i = 0; i < 9; i++)
        begin
            c = $urandom_range(7);
            d = {xf[i % 3], 2'($urandom), 2'(i / 3), 2'(c)};
            md[c] = d[7:2];
            wr(c > 3 ? 8'hD6 : 8'h0B, d);
        end
        settle(3);
        chk_modes();
        $display("mode test done");
        mk = 8'($urandom);
        wr(8'h0F, {4'h0, mk[3:0]});
        wr(8'hDE, {4'h0, mk[7:4]});
        settle(3);
        chk({8'h0, chan_mask_o}, {8'h0, mk});
        rd(8'hDE, {4'h0, mk[7:4]});
        wr(8'h0E, 8'h5A);
        settle(3);
        chk({8'h0, chan_mask_o}, {8'h0, mk[7:4], 4'h0});
        $display("mask test done");
        wr(8'hDC, 8'hA5);
        settle(1);
        raise = 8'hFF;
        settle(8);
        chk({chan_req_o, status_o[15:12], status_o[7:4]}, 16'hFFFF);
        // reserved transfer mode on channel 3 drops its request
        md[3] = 6'h20;
        wr(8'h0B, 8'h83);
        settle(3);
        chk({8'h0, chan_req_o}, 16'h00F7);
        wr(8'hDE, 8'h01);
        settle(3);
        chk({8'h0, chan_req_o}, 16'h00E0);
        raise = 8'h00;
        $display("request test done");
        md[1] = 6'h05;
        md[2] = 6'h01;
        wr(8'h0B, 8'h15);
        wr(8'h0B, 8'h06);
        settle(3);
        tc_i = 8'h06;
        @(negedge clk_i);
        tc_i = 8'h00;
        chk({chan_reload_o, chan_mask_o}, 16'h0214);
        chk({12'h0, status_o[3:0]}, 16'h0006);
        $display("terminal count test done");
        wr(8'h0C, 8'h00);
        wr(8'hD8, 8'h00);
        settle(3);
        word_access_i = 2'h3;
        @(negedge clk_i);
        word_access_i = 2'h1;
        @(negedge clk_i);
        word_access_i = 2'h0;
        chk({14'h0, byte_high_o}, 16'h0002);
        wr(8'hD8, 8'h00);
        settle(3);
        chk({14'h0, byte_high_o}, 16'h0000);
        // low group pointer cleared through its own port
        word_access_i = 2'h1;
        @(negedge clk_i);
        word_access_i = 2'h0;
        chk({14'h0, byte_high_o}, 16'h0001);
        wr(8'h0C, 8'h00);
        settle(3);
        chk({14'h0, byte_high_o}, 16'h0000);
        word_access_i = 2'h2;
        @(negedge clk_i);
        word_access_i = 2'h0;
        wr(8'hDA, 8'h3C);
        settle(1);
        chk({14'h0, group_clear_o}, 16'h0002);
        settle(2);
        for (i = 4; i < 8; i++)
            md[i][3:2] = 2'h0;
        chk({chan_mask_o, 6'h0, byte_high_o}, 16'hF400);
        chk_modes();
        $display("pointer and clear test done");
        cfg_hold_i = 1'b1;
        for (i = 0; i < 32; i++)
            wr(8'h40, 8'($urandom));
        chk({14'h0, io_wr_ready_o, io_rd_ready_o}, 16'h0000);
        settle(1);
        cfg_hold_i = 1'b0;
        rd(8'h40, 8'h00);
        chk({15'h0, io_wr_ready_o}, 16'h0001);
        $display("queue test done");
        summarize();
    end
endmodule

/* dv/ldm_dreq_model.sv */
`timescale 1ns/10ps
module ldm_dreq_model (
    // clock and wish from the bench
    input  wire logic       clk_i,
    input  wire logic [7:0] raise_i,
    // request pins
    output logic      [7:0] dreq_o = 8'h00
);
    logic [1:0] lag = 2'h0;

    // devices answer after a random 0-3 cycle lag and drop at once
    always @(negedge clk_i)
    begin
        if (raise_i == 8'h00)
            lag <= 2'($urandom);
        else if (lag != 2'h0)
            lag <= lag - 2'h1;
        dreq_o <= (lag == 2'h0) ? raise_i : 8'h00;
    end
endmodule

/* rtl/ldm_ctrl.sv */
// Operation
// - mode bits 7:6: demand, single, cascade
// - bit 5 picks increment or decrement
// - bit 4 autoinit reloads at terminal count
// - bits 3:2 pick verify, write, read
// - bits 1:0 pick channel storing bits 7:2
// - clear byte pointer write resets flip-flop
// - low byte first, toggles each access
// - reset and master clear clear flip-flop
// - master clear resets its group but keeps transfer mode and type bits
// - clear mask write unmasks all four
// - all-mask write loads bits 3:0
// - all-mask read returns mask bits
// - terminal count masks channel unless autoinit
// - reset and master clear set masks
// - masking channel 4 blocks channels 0-3
// - status shows terminal count and requests
`timescale 1ns/10ps
`include "ldm_defines.svh"

module ldm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;

    // extra pointer bit tells full from empty
    assign empty       = (wr_ptr == rd_ptr);
    assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];

    // pointers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (in_valid_i && !full)
                wr_ptr <= wr_ptr + 1'b1;
            if (out_ready_i && !empty)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk_i)
    begin
        if (in_valid_i && !full)
            mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
endmodule

module ldm_ctrl
    import ldm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // host i/o port access
    input  wire logic [7:0]  io_addr_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic        io_wr_i,
    output logic             io_wr_ready_o,
    input  wire logic        io_rd_i,
    output logic             io_rd_ready_o,
    output logic [7:0]       io_rdata_o,
    output logic             io_rd_valid_o,
    // transfer engine side
    input  wire logic        cfg_hold_i,
    input  wire logic [1:0]  word_access_i,
    input  wire logic [7:0]  tc_i,
    output logic [1:0]       byte_high_o,
    output logic [1:0]       group_clear_o,
    output logic [15:0]      chan_xfer_o,
    output logic [7:0]       chan_decr_o,
    output logic [7:0]       chan_auto_o,
    output logic [15:0]      chan_type_o,
    output logic [7:0]       chan_reload_o,
    output logic [7:0]       chan_mask_o,
    output logic [7:0]       chan_req_o,
    output logic [15:0]      status_o,
    // request pins from i/o devices
    input  wire logic [7:0]  dreq_i
);
    ldm_state_s st;
    ldm_state_s next_st;

    logic        q_valid;
    logic        q_ready;
    logic [15:0] q_data;
    logic [7:0]  q_addr;
    logic [7:0]  q_wdata;
    logic        do_cmd;
    logic [1:0]  hit_mode;
    logic [1:0]  hit_bptr;
    logic [1:0]  hit_mclr;
    logic [1:0]  hit_clrm;
    logic [1:0]  hit_wrm;
    logic [1:0]  rd_hit;
    logic [7:0]  req_raw;

    // writes queue up so the engine can hold config steady mid-transfer
    ldm_fifo #(
        .WIDTH (`LDM_CMDQ_WIDTH),
        .DEPTH (`LDM_CMDQ_DEPTH)
    ) u_cmdq (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (io_wr_i),
        .in_ready_o  (io_wr_ready_o),
        .in_data_i   ({io_addr_i, io_wdata_i}),
        .out_valid_o (q_valid),
        .out_ready_i (q_ready),
        .out_data_o  (q_data)
    );

    // drain stalls while the engine holds configuration
    assign q_ready = ~cfg_hold_i;
    assign do_cmd  = q_valid & q_ready;
    assign q_addr  = q_data[15:8];
    assign q_wdata = q_data[7:0];

    // reads wait until queued writes have landed, keeping order
    assign io_rd_ready_o = ~q_valid;

    // per-group port decode
    localparam logic [7:0] MODE_A [2] = '{`LDM_LO_MODE_ADDR, `LDM_HI_MODE_ADDR};
    localparam logic [7:0] BPTR_A [2] = '{`LDM_LO_CLR_BPTR_ADDR, `LDM_HI_CLR_BPTR_ADDR};
    localparam logic [7:0] MCLR_A [2] = '{`LDM_LO_MCLR_ADDR, `LDM_HI_MCLR_ADDR};
    localparam logic [7:0] CLRM_A [2] = '{`LDM_LO_CLR_MASK_ADDR, `LDM_HI_CLR_MASK_ADDR};
    localparam logic [7:0] WRM_A  [2] = '{`LDM_LO_WR_MASK_ADDR, `LDM_HI_WR_MASK_ADDR};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_dec
            assign hit_mode[g] = do_cmd && (q_addr == MODE_A[g]);
            assign hit_bptr[g] = do_cmd && (q_addr == BPTR_A[g]);
            assign hit_mclr[g] = do_cmd && (q_addr == MCLR_A[g]);
            assign hit_clrm[g] = do_cmd && (q_addr == CLRM_A[g]);
            assign hit_wrm[g]  = do_cmd && (q_addr == WRM_A[g]);
            assign rd_hit[g]   = (io_addr_i == WRM_A[g]);
        end
    endgenerate

    // requests reach the engine only through synced, unmasked pins
    genvar c;
    generate
        for (c = 0; c < 8; c++)
        begin : g_req
            if (c < 4)
            begin : g_lo
                // low group is cascaded through channel 4
                assign req_raw[c] = st.sync2[c] & ~st.mask[c] & ~st.mask[4];
            end
            else
            begin : g_hi
                assign req_raw[c] = st.sync2[c] & ~st.mask[c];
            end
            assign chan_xfer_o[2*c+1:2*c] = st.mode[c][`LDM_ST_XFER_MSB:`LDM_ST_XFER_LSB];
            assign chan_decr_o[c]         = st.mode[c][`LDM_ST_DECR_BIT];
            assign chan_auto_o[c]         = st.mode[c][`LDM_ST_AUTO_BIT];
            // type means nothing for cascade channels
            assign chan_type_o[2*c+1:2*c] =
                (ldm_xfer_e'(st.mode[c][`LDM_ST_XFER_MSB:`LDM_ST_XFER_LSB]) == LDM_XFER_CASCADE)
                ? LDM_TYPE_VERIFY : st.mode[c][`LDM_ST_TYPE_MSB:`LDM_ST_TYPE_LSB];
        end
    endgenerate

    // a reserved transfer mode never forwards a request
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            chan_req_o[i] = req_raw[i] &&
                (ldm_xfer_e'(st.mode[i][`LDM_ST_XFER_MSB:`LDM_ST_XFER_LSB]) != LDM_XFER_RESERVED);
    end

    // status bytes: request bits 7:4, terminal count bits 3:0
    always_comb
    begin
        status_o[7:0]  = {chan_req_o[3:0], st.tc_st[3:0]};
        // channel 4 request shows the cascaded low group too
        status_o[15:8] = {chan_req_o[7:5], chan_req_o[4] | (|chan_req_o[3:0]),
                          st.tc_st[7:4]};
    end

    assign byte_high_o   = st.bptr;
    assign group_clear_o = st.mclr;
    assign chan_reload_o = st.reload;
    assign chan_mask_o   = st.mask;
    assign io_rdata_o    = st.rdata;
    assign io_rd_valid_o = st.rd_valid;

    // next-state logic; hardware sets are applied last so they win
    always_comb
    begin
        logic [2:0] sel;
        next_st          = st;
        sel              = 3'h0;
        next_st.sync1    = dreq_i;
        next_st.sync2    = st.sync1;
        next_st.reload   = 8'h00;
        next_st.mclr     = 2'b00;
        next_st.rd_valid = 1'b0;

        for (int gi = 0; gi < 2; gi++)
        begin
            // byte pointer toggles per 16-bit access
            if (word_access_i[gi])
                next_st.bptr[gi] = ~st.bptr[gi];
            // software issues clear before first access
            if (hit_bptr[gi])
                next_st.bptr[gi] = 1'b0;

            if (hit_mode[gi])
            begin
                sel = {gi[0], q_wdata[`LDM_MODE_SEL_MSB:`LDM_MODE_SEL_LSB]};
                next_st.mode[sel] = q_wdata[`LDM_MODE_XFER_MSB:`LDM_MODE_TYPE_LSB];
            end
            if (hit_clrm[gi])
                next_st.mask[gi*4 +: 4] = 4'h0;
            // upper bits are don't-care, software keeps them zero
            if (hit_wrm[gi])
                next_st.mask[gi*4 +: 4] = q_wdata[3:0];

            if (hit_mclr[gi])
            begin
                next_st.bptr[gi]         = 1'b0;
                next_st.mask[gi*4 +: 4]  = `LDM_MASK_RST;
                next_st.tc_st[gi*4 +: 4] = 4'h0;
                next_st.mclr[gi]         = 1'b1;
                for (int k = 0; k < 4; k++)
                begin
                    next_st.mode[gi*4+k][`LDM_ST_DECR_BIT] = 1'b0;
                    next_st.mode[gi*4+k][`LDM_ST_AUTO_BIT] = 1'b0;
                end
            end

            // register read of the all-mask port
            if (io_rd_i && io_rd_ready_o && rd_hit[gi])
                next_st.rdata = {4'h0, st.mask[gi*4 +: 4]};
        end

        // any accepted read answers; unmapped reads give a fixed value
        if (io_rd_i && io_rd_ready_o)
        begin
            next_st.rd_valid = 1'b1;
            if (rd_hit == 2'b00)
                next_st.rdata = `LDM_RDATA_UNMAPPED;
        end

        // terminal count: status set, then reload or self-mask
        for (int ci = 0; ci < 8; ci++)
        begin
            if (tc_i[ci])
            begin
                next_st.tc_st[ci] = 1'b1;
                if (st.mode[ci][`LDM_ST_AUTO_BIT])
                    next_st.reload[ci] = 1'b1;
                else
                    next_st.mask[ci] = 1'b1;
            end
        end
    end

    // single state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st          <= '0;
            st.mask     <= {`LDM_MASK_RST, `LDM_MASK_RST};
            st.mode     <= {8{`LDM_MODE_RST}};
            st.bptr     <= 2'b00;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

/* rtl/ldm_defines.svh */
`ifndef LDM_DEFINES_SVH
`define LDM_DEFINES_SVH

// port addresses, channel 0-3 group
`define LDM_LO_MODE_ADDR      8'h0B
`define LDM_LO_CLR_BPTR_ADDR  8'h0C
`define LDM_LO_MCLR_ADDR      8'h0D
`define LDM_LO_CLR_MASK_ADDR  8'h0E
`define LDM_LO_WR_MASK_ADDR   8'h0F

// port addresses, channel 4-7 group
`define LDM_HI_MODE_ADDR      8'hD6
`define LDM_HI_CLR_BPTR_ADDR  8'hD8
`define LDM_HI_MCLR_ADDR      8'hDA
`define LDM_HI_CLR_MASK_ADDR  8'hDC
`define LDM_HI_WR_MASK_ADDR   8'hDE

// mode byte fields
`define LDM_MODE_XFER_MSB     7
`define LDM_MODE_XFER_LSB     6
`define LDM_MODE_DECR_BIT     5
`define LDM_MODE_AUTO_BIT     4
`define LDM_MODE_TYPE_MSB     3
`define LDM_MODE_TYPE_LSB     2
`define LDM_MODE_SEL_MSB      1
`define LDM_MODE_SEL_LSB      0

// stored mode fields (bits 7:2 of the mode byte)
`define LDM_ST_XFER_MSB       5
`define LDM_ST_XFER_LSB       4
`define LDM_ST_DECR_BIT       3
`define LDM_ST_AUTO_BIT       2
`define LDM_ST_TYPE_MSB       1
`define LDM_ST_TYPE_LSB       0

// reset values
`define LDM_MODE_RST          6'h00
`define LDM_MASK_RST          4'hF
`define LDM_RDATA_UNMAPPED    8'h00

// command queue shape
`define LDM_CMDQ_WIDTH        16
`define LDM_CMDQ_DEPTH        32

`endif

/* rtl/ldm_pkg.sv */
package ldm_pkg;

    // transfer mode, bits 7:6
    typedef enum logic [1:0] {
        LDM_XFER_DEMAND   = 2'h0,
        LDM_XFER_SINGLE   = 2'h1,
        LDM_XFER_RESERVED = 2'h2,
        LDM_XFER_CASCADE  = 2'h3
    } ldm_xfer_e;

    // transfer type, bits 3:2
    typedef enum logic [1:0] {
        LDM_TYPE_VERIFY  = 2'h0,
        LDM_TYPE_IO2MEM  = 2'h1,
        LDM_TYPE_MEM2IO  = 2'h2,
        LDM_TYPE_ILLEGAL = 2'h3
    } ldm_type_e;

    typedef logic [5:0] ldm_mode_t;

    // whole state of the control block except the command queue
    typedef struct packed {
        ldm_mode_t [7:0] mode;
        logic [7:0]      mask;
        logic [1:0]      bptr;
        logic [7:0]      tc_st;
        logic [7:0]      sync1;
        logic [7:0]      sync2;
        logic [7:0]      reload;
        logic [1:0]      mclr;
        logic [7:0]      rdata;
        logic            rd_valid;
    } ldm_state_s;

endpackage
